// file: design/mie_defs.svh
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH

// ****************************************
// Reset values and constants
// ****************************************
`define MIE_ACC_RST 8'h00
`define MIE_PC_RST 15'h0000
`define MIE_ZERO8 8'h00
`define MIE_ONE8 8'h01
`define MIE_PC_ONE 15'h0001
`define MIE_PC_TWO 15'h0002

// ****************************************
// Field positions of the program counter
// ****************************************
`define MIE_PC_LO_MSB 7
`define MIE_PC_HI_MSB 14
`define MIE_PCH_MSB 6

// ****************************************
// Default sizes
// ****************************************
`define MIE_STACK_DEPTH 16
`define MIE_WDT_WIDTH 8
`define MIE_PRESCALE_WIDTH 8

`endif

// file: design/mie_pkg.sv
package mie_pkg;

  // ****************************************
  // Operation codes of the executed subset
  // ****************************************
  typedef enum logic [2:0] {
    MIE_OP_NOP,
    MIE_OP_KICK_WATCHDOG,
    MIE_OP_INDIRECT_CALL,
    MIE_OP_INVERT_REG,
    MIE_OP_ZERO_REG,
    MIE_OP_ZERO_ACCUM,
    MIE_OP_REG_MINUS_ONE,
    MIE_OP_DEC_SKIP_ZERO
  } mie_opcode_e;

  // Sequencer states
  typedef enum logic {
    MIE_ST_RUN,
    MIE_ST_SECOND
  } mie_state_e;

  // One issued operation
  typedef struct packed {
    mie_opcode_e code;
    logic dest_file;
    logic [6:0] file_addr;
  } mie_op_s;

  // Status flags
  typedef struct packed {
    logic null_result_flag;
    logic timeout_flag_n;
    logic powerdown_flag;
  } mie_flags_s;

endpackage : mie_pkg

// file: design/mie_exec.sv
`timescale 1ns/100ps
`default_nettype none
`include "mie_defs.svh"

module mie_exec #(
  parameter int STACK_DEPTH = `MIE_STACK_DEPTH,
  parameter int WDT_WIDTH = `MIE_WDT_WIDTH,
  parameter int PRESCALE_WIDTH = `MIE_PRESCALE_WIDTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire mie_pkg::mie_op_s op,
  input wire logic [6:0] pc_high_latch,
  input wire logic [6:0] file_rd_addr,
  output logic op_ready,
  output logic [14:0] pc,
  output logic [7:0] accumulator_reg,
  output var mie_pkg::mie_flags_s flags,
  output logic [14:0] stack_head,
  output logic [WDT_WIDTH-1:0] watchdog_count,
  output logic [PRESCALE_WIDTH-1:0] prescaler,
  output logic [7:0] file_rd_data
);

  // ****************************************
  // Storage
  // ****************************************
  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  logic [7:0] file_mem [0:127]; // File registers
  logic [14:0] stack_mem [0:STACK_DEPTH-1]; // Return stack
  logic [SP_W-1:0] stack_ptr; // Next free slot, wraps on overflow
  mie_pkg::mie_state_e state; // Sequencer state

  // ****************************************
  // Decode
  // ****************************************
  logic accept; // Operation taken this cycle
  logic [7:0] operand; // Addressed file register
  logic [7:0] result; // Eight-bit operation result
  logic write_acc; // Result goes to accumulator
  logic write_file; // Result goes to file register
  logic touch_zero; // Zero flag is updated
  logic skip_taken; // Next instruction becomes a no-operation

  // Operation with a destination select bit
  function automatic logic has_dest(input mie_pkg::mie_opcode_e c);
    has_dest = (c == mie_pkg::MIE_OP_INVERT_REG) || (c == mie_pkg::MIE_OP_REG_MINUS_ONE) ||
               (c == mie_pkg::MIE_OP_DEC_SKIP_ZERO);
  endfunction : has_dest

  assign accept = op_valid && op_ready;
  assign operand = file_mem[op.file_addr];

  // Result and routing of each operation
  always_comb begin
    result = `MIE_ZERO8;
    touch_zero = 1'b0;
    skip_taken = 1'b0;
    case (op.code)
      mie_pkg::MIE_OP_INVERT_REG: begin
        result = ~operand;
        touch_zero = 1'b1;
      end
      mie_pkg::MIE_OP_ZERO_REG: begin
        result = `MIE_ZERO8;
        touch_zero = 1'b1;
      end
      mie_pkg::MIE_OP_ZERO_ACCUM: begin
        result = `MIE_ZERO8;
        touch_zero = 1'b1;
      end
      mie_pkg::MIE_OP_REG_MINUS_ONE: begin
        result = operand - `MIE_ONE8;
        touch_zero = 1'b1;
      end
      mie_pkg::MIE_OP_DEC_SKIP_ZERO: begin
        result = operand - `MIE_ONE8;
        skip_taken = (result == `MIE_ZERO8);
      end
      default: begin
        result = `MIE_ZERO8;
      end
    endcase
    // Destination select routes results of routed operations
    write_acc = accept && ((has_dest(op.code) && !op.dest_file) ||
                op.code == mie_pkg::MIE_OP_ZERO_ACCUM);
    write_file = accept && ((has_dest(op.code) && op.dest_file) ||
                 op.code == mie_pkg::MIE_OP_ZERO_REG);
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Two-cycle operations hold off the next issue for one cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= mie_pkg::MIE_ST_RUN;
      op_ready <= 1'b1;
    end else begin
      case (state)
        mie_pkg::MIE_ST_RUN: begin
          if (accept && (op.code == mie_pkg::MIE_OP_INDIRECT_CALL || skip_taken)) begin
            state <= mie_pkg::MIE_ST_SECOND;
            op_ready <= 1'b0;
          end
        end
        mie_pkg::MIE_ST_SECOND: begin
          state <= mie_pkg::MIE_ST_RUN;
          op_ready <= 1'b1;
        end
        default: begin
          state <= mie_pkg::MIE_ST_RUN;
          op_ready <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Program counter and return stack
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pc <= `MIE_PC_RST;
    end else if (accept) begin
      if (op.code == mie_pkg::MIE_OP_INDIRECT_CALL) begin
        pc <= {pc_high_latch[`MIE_PCH_MSB:0], accumulator_reg};
      end else if (skip_taken) begin
        pc <= pc + `MIE_PC_TWO;
      end else begin
        pc <= pc + `MIE_PC_ONE;
      end
    end
  end

  // Push of the return address
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stack_ptr <= '0;
      stack_head <= `MIE_PC_RST;
    end else if (accept && op.code == mie_pkg::MIE_OP_INDIRECT_CALL) begin
      stack_ptr <= stack_ptr + 1'b1;
      stack_head <= pc + `MIE_PC_ONE;
    end
  end

  // Stack body, no reset needed
  always_ff @(posedge clock) begin
    if (accept && op.code == mie_pkg::MIE_OP_INDIRECT_CALL) begin
      stack_mem[stack_ptr] <= pc + `MIE_PC_ONE;
    end
  end

  // ****************************************
  // Accumulator and file registers
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      accumulator_reg <= `MIE_ACC_RST;
    end else if (write_acc) begin
      accumulator_reg <= result;
    end
  end

  // File registers, with a registered read port for observation
  always_ff @(posedge clock) begin
    if (write_file) begin
      file_mem[op.file_addr] <= result;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      file_rd_data <= `MIE_ZERO8;
    end else begin
      file_rd_data <= file_mem[file_rd_addr];
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Calls and skips leave flags alone; only listed operations touch them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags <= '{null_result_flag: 1'b0, timeout_flag_n: 1'b1, powerdown_flag: 1'b1};
    end else if (accept) begin
      if (touch_zero) begin
        flags.null_result_flag <= (result == `MIE_ZERO8);
      end
      if (op.code == mie_pkg::MIE_OP_KICK_WATCHDOG) begin
        flags.timeout_flag_n <= 1'b1;
        flags.powerdown_flag <= 1'b1;
      end
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  // Prescaler counts every clock except a kick, which clears both; the count steps when it wraps
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prescaler <= '0;
      watchdog_count <= '0;
    end else if (accept && op.code == mie_pkg::MIE_OP_KICK_WATCHDOG) begin
      prescaler <= '0;
      watchdog_count <= '0;
    end else begin
      prescaler <= prescaler + 1'b1;
      if (&prescaler) begin
        watchdog_count <= watchdog_count + 1'b1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic is_kick, is_call, is_inv, is_dec;
  assign is_kick = accept && op.code == mie_pkg::MIE_OP_KICK_WATCHDOG;
  assign is_call = accept && op.code == mie_pkg::MIE_OP_INDIRECT_CALL;
  assign is_inv = accept && op.code == mie_pkg::MIE_OP_INVERT_REG;
  assign is_dec = accept && op.code == mie_pkg::MIE_OP_REG_MINUS_ONE;

  kick_count_a: assert property (is_kick |=> watchdog_count == '0)
    else $error("watchdog count not cleared");
  kick_prescale_a: assert property (is_kick |=> prescaler == '0)
    else $error("prescaler not cleared");
  kick_flags_a: assert property (is_kick |=> flags.timeout_flag_n && flags.powerdown_flag)
    else $error("kick did not set status bits");
  call_push_a: assert property (is_call |=> stack_head == $past(pc) + `MIE_PC_ONE)
    else $error("return address wrong");
  stack_body_a: assert property (is_call |=> stack_mem[stack_ptr - 1'b1] == stack_head)
    else $error("pushed slot differs from stack head");
  call_target_a: assert property (is_call |=>
      pc == {$past(pc_high_latch), $past(accumulator_reg)})
    else $error("call target wrong");
  call_two_a: assert property (is_call |=> !op_ready && $stable(flags) ##1 op_ready)
    else $error("call not two cycles or flags moved");
  invert_acc_a: assert property (is_inv && !op.dest_file |=>
      accumulator_reg == ~$past(operand) &&
      flags.null_result_flag == (accumulator_reg == `MIE_ZERO8))
    else $error("complement result wrong");
  zero_reg_a: assert property (accept && op.code == mie_pkg::MIE_OP_ZERO_REG |=>
      flags.null_result_flag)
    else $error("zero flag not set after register clear");
  zero_acc_a: assert property (accept && op.code == mie_pkg::MIE_OP_ZERO_ACCUM |=>
      accumulator_reg == `MIE_ZERO8 && flags.null_result_flag)
    else $error("accumulator clear wrong");
  dec_acc_a: assert property (is_dec && !op.dest_file |=>
      accumulator_reg == $past(operand) - `MIE_ONE8 &&
      flags.null_result_flag == (accumulator_reg == `MIE_ZERO8))
    else $error("decrement result wrong");
  dec_file_a: assert property (is_dec && op.dest_file |=>
      $stable(accumulator_reg))
    else $error("file destination touched accumulator");
  skip_taken_a: assert property (accept && skip_taken |=>
      !op_ready && pc == $past(pc) + `MIE_PC_TWO && $stable(flags))
    else $error("skip not taken correctly");
  single_cycle_a: assert property (accept && !is_call && !skip_taken |=> op_ready)
    else $error("single-cycle operation stalled");

  call_seen_c: cover property (is_call ##2 accept);
  skip_seen_c: cover property (accept && skip_taken);
  kick_seen_c: cover property (is_kick);
  dec_zero_c: cover property (is_dec ##1 flags.null_result_flag);

endmodule : mie_exec
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Testbench for the instruction subset
// ****************************************
module tb_top;
  logic clock; // 50 MHz clock
  logic reset_n; // Active low reset
  logic op_valid; // Operation offered
  mie_pkg::mie_op_s op; // Operation fields
  logic [6:0] pc_high_latch; // Call target high bits
  logic [6:0] file_rd_addr; // Observation address
  logic op_ready;
  logic [14:0] pc;
  logic [7:0] accumulator_reg;
  mie_pkg::mie_flags_s flags;
  logic [14:0] stack_head;
  logic [7:0] watchdog_count;
  logic [7:0] prescaler;
  logic [7:0] file_rd_data;
  int errors; // Mismatch count
  int n_compared; // Comparison count
  int cycles; // Clock cycles since start
  logic [14:0] exp_pc; // Expected program counter

  mie_exec i_dut (.clock(clock), .reset_n(reset_n), .op_valid(op_valid), .op(op),
    .pc_high_latch(pc_high_latch), .file_rd_addr(file_rd_addr), .op_ready(op_ready), .pc(pc),
    .accumulator_reg(accumulator_reg), .flags(flags), .stack_head(stack_head),
    .watchdog_count(watchdog_count), .prescaler(prescaler), .file_rd_data(file_rd_data));

  // Free running clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Hang guard: the run needs about 900 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  // Compare one value
  task cmp(input logic [14:0] got, input logic [14:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Offer one operation, return just after the clock edge that takes it, valid still high
  task do_op(input mie_pkg::mie_opcode_e code, input logic dest, input logic [6:0] addr,
    input logic [6:0] latch);
    int w;
    op_valid = 1'b1;
    op.code = code;
    op.dest_file = dest;
    op.file_addr = addr;
    pc_high_latch = latch;
    w = 0;
    while (op_ready !== 1'b1 && w < 20) begin
      @(posedge clock);
      #1;
      w++;
    end
    @(posedge clock);
    #1;
  endtask : do_op

  // Release the operation port for one cycle
  task idle();
    op_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask : idle

  // Read one file register through the observation port
  task rd(input logic [6:0] addr, input logic [7:0] exp);
    file_rd_addr = addr;
    @(posedge clock);
    #1;
    cmp({7'h00, file_rd_data}, {7'h00, exp});
  endtask : rd

  // Single cycle operation: program counter steps by one
  task step_pc();
    exp_pc = exp_pc + 15'h0001;
    cmp(pc, exp_pc);
  endtask : step_pc

  // ****************************************
  // Scenarios
  // ****************************************
  // Clear file register 7f at the top of the address range, then register 05
  task t_clear();
    do_op(mie_pkg::MIE_OP_ZERO_REG, 1'b0, 7'h7f, 7'h00);
    step_pc();
    cmp(flags.null_result_flag, 1'b1);
    do_op(mie_pkg::MIE_OP_ZERO_REG, 1'b1, 7'h05, 7'h00);
    step_pc();
    idle();
    rd(7'h7f, 8'h00);
    rd(7'h05, 8'h00);
    $display("test clear done");
  endtask : t_clear

  // Complement, decrement and clear accumulator, back to back
  task t_arith();
    do_op(mie_pkg::MIE_OP_INVERT_REG, 1'b1, 7'h05, 7'h00);
    step_pc();
    cmp(flags.null_result_flag, 1'b0);
    do_op(mie_pkg::MIE_OP_INVERT_REG, 1'b0, 7'h05, 7'h00);
    step_pc();
    cmp(accumulator_reg, 8'h00);
    cmp(flags.null_result_flag, 1'b1);
    do_op(mie_pkg::MIE_OP_REG_MINUS_ONE, 1'b0, 7'h05, 7'h00);
    step_pc();
    cmp(accumulator_reg, 8'hfe);
    cmp(flags.null_result_flag, 1'b0);
    do_op(mie_pkg::MIE_OP_ZERO_ACCUM, 1'b0, 7'h05, 7'h00);
    step_pc();
    cmp(accumulator_reg, 8'h00);
    cmp(flags.null_result_flag, 1'b1);
    do_op(mie_pkg::MIE_OP_REG_MINUS_ONE, 1'b1, 7'h05, 7'h00);
    step_pc();
    cmp(accumulator_reg, 8'h00);
    idle();
    rd(7'h05, 8'hfe);
    $display("test arith done");
  endtask : t_arith

  // Decrement and skip, first without a skip, then with one
  task t_skip();
    do_op(mie_pkg::MIE_OP_ZERO_REG, 1'b1, 7'h06, 7'h00);
    step_pc();
    do_op(mie_pkg::MIE_OP_DEC_SKIP_ZERO, 1'b1, 7'h06, 7'h00);
    step_pc();
    cmp(flags.null_result_flag, 1'b1);
    for (int i = 0; i < 254; i++) begin
      do_op(mie_pkg::MIE_OP_REG_MINUS_ONE, 1'b1, 7'h06, 7'h00);
    end
    exp_pc = exp_pc + 15'h00fe;
    cmp(pc, exp_pc);
    do_op(mie_pkg::MIE_OP_REG_MINUS_ONE, 1'b0, 7'h06, 7'h00);
    step_pc();
    cmp(flags.null_result_flag, 1'b1);
    do_op(mie_pkg::MIE_OP_INVERT_REG, 1'b0, 7'h06, 7'h00);
    step_pc();
    cmp(accumulator_reg, 8'hfe);
    do_op(mie_pkg::MIE_OP_DEC_SKIP_ZERO, 1'b1, 7'h06, 7'h00);
    exp_pc = exp_pc + 15'h0002;
    cmp(pc, exp_pc);
    cmp(op_ready, 1'b0);
    cmp(flags.null_result_flag, 1'b0);
    idle();
    cmp(op_ready, 1'b1);
    rd(7'h06, 8'h00);
    $display("test skip done");
  endtask : t_skip

  // Indirect call, then an operation that must wait one cycle
  task t_call();
    logic [14:0] ret;
    ret = exp_pc + 15'h0001;
    do_op(mie_pkg::MIE_OP_INDIRECT_CALL, 1'b0, 7'h00, 7'h55);
    cmp(stack_head, ret);
    cmp(pc, {7'h55, 8'hfe});
    cmp(op_ready, 1'b0);
    cmp(flags, 3'h3);
    do_op(mie_pkg::MIE_OP_ZERO_ACCUM, 1'b0, 7'h00, 7'h00);
    exp_pc = {7'h55, 8'hfe};
    step_pc();
    cmp(stack_head, ret);
    idle();
    $display("test call done");
  endtask : t_call

  // Watchdog kick after the counters have run
  task t_kick();
    repeat (600) @(posedge clock);
    #1;
    do_op(mie_pkg::MIE_OP_KICK_WATCHDOG, 1'b0, 7'h00, 7'h00);
    step_pc();
    cmp(watchdog_count, 8'h00);
    cmp(prescaler, 8'h00);
    cmp(flags.timeout_flag_n, 1'b1);
    cmp(flags.powerdown_flag, 1'b1);
    do_op(mie_pkg::MIE_OP_NOP, 1'b0, 7'h00, 7'h00);
    step_pc();
    cmp(accumulator_reg, 8'h00);
    idle();
    $display("test kick done");
  endtask : t_kick

  // Print the counts and the verdict, then stop
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    op_valid = 1'b0;
    op = '0;
    pc_high_latch = 7'h00;
    file_rd_addr = 7'h00;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    exp_pc = 15'h0000;
    repeat (10) @(posedge clock);
    #1;
    reset_n = 1'b1;
    cmp(pc, 15'h0000);
    cmp(flags, 3'h3);
    t_clear();
    t_arith();
    t_skip();
    t_call();
    t_kick();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
